// ### smblt_pkg.sv
// smblt_pkg: constants, types and states shared by the bus timing logic
// assumes a 100 MHz system clock; counts below are derived from it
package smblt_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned TMR_W = 10;

  // protocol times in their printed units
  localparam int unsigned TIMEOUT_MS = 25;
  localparam int unsigned HIGH_MAX_US = 50;
  localparam int unsigned SEXT_MS = 25;
  localparam int unsigned MEXT_MS = 10;
  localparam int unsigned MASTER_HZ_X10 = 512_000;

  // cycle counts: least times round up, master half period rounds down
  localparam int unsigned US_CYC = (CLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;
  localparam int unsigned HIGH_CYC = US_CYC * HIGH_MAX_US;
  localparam int unsigned SEXT_CYC = (CLK_HZ / 1000) * SEXT_MS;
  localparam int unsigned MEXT_CYC = (CLK_HZ / 1000) * MEXT_MS;
  localparam int unsigned HALF_CYC = (CLK_HZ / 2) * 10 / MASTER_HZ_X10;

  // broadcast frame layout
  localparam logic [1:0] LAST_BYTE = 2'h3;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [2:0] MSB_POS = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SLAVE = 3'b001,
    ST_M_START = 3'b010,
    ST_M_LOW = 3'b011,
    ST_M_HIGH = 3'b100,
    ST_M_STOP_LOW = 3'b101,
    ST_M_STOP_HIGH = 3'b110
  } smblt_state_t;

  typedef struct packed {
    logic clock_high_limit_select;
    logic [15:0] clock_high_limit_value;
    logic slave_stretch_req;
    logic broadcast_req;
    logic [15:0] charge_current;
    logic [15:0] charge_voltage;
  } smblt_ctrl_t;

  typedef struct packed {
    logic bus_free;
    logic slave_active;
    logic master_busy;
    logic timeout_err;
    logic idle_reset;
    logic slave_stretch_over;
    logic master_stretch_over;
    logic master_nack;
    logic broadcast_done;
  } smblt_status_t;

  // what the link front end hands to the system side
  typedef struct packed {
    logic scl_lvl;
    logic sda_lvl;
    logic start_tgl;
    logic stop_tgl;
  } smblt_link_t;

endpackage : smblt_pkg

// ### smblt_link_fe.sv
// smblt_link_fe: pin front end on the link clock
// samples both bus pins, finds start and stop, drives the open-drain pins
// assumes drive requests come from flops of the system clock domain
`timescale 1ns/1ps
`default_nettype none
module smblt_link_fe (
  input wire logic link_clk_i,
  input wire logic rst_n_i,
  input wire logic serial_clock_pin_i,
  input wire logic serial_data_pin_i,
  input wire logic scl_low_req_i,
  input wire logic sda_low_req_i,
  output var smblt_pkg::smblt_link_t link_o,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_o,
  output logic serial_data_pin_o,
  output logic serial_data_pin_oe_o
);
  import smblt_pkg::*;

  typedef struct packed {
    logic rst_m, rst_s;
    logic scl_m, scl_s;
    logic sda_m, sda_s, sda_p;
    logic sclr_m, sclr_s;
    logic sdar_m, sdar_s;
    logic lvl;
    smblt_link_t lk;
  } smblt_fe_t;

  smblt_fe_t q, d;

  // next state; reset is taken through two flops of this domain
  always_comb begin
    d = q;
    d.rst_m = rst_n_i;
    d.rst_s = q.rst_m;
    d.scl_m = serial_clock_pin_i;
    d.scl_s = q.scl_m;
    d.sda_m = serial_data_pin_i;
    d.sda_s = q.sda_m;
    d.sda_p = q.sda_s;
    d.sclr_m = scl_low_req_i;
    d.sclr_s = q.sclr_m;
    d.sdar_m = sda_low_req_i;
    d.sdar_s = q.sdar_m;
    d.lvl = 1'b0;
    d.lk.scl_lvl = q.scl_s;
    d.lk.sda_lvl = q.sda_s;
    // data edges while the clock is high mark frame bounds
    if (q.scl_s && q.sda_p && !q.sda_s) begin
      d.lk.start_tgl = ~q.lk.start_tgl;
    end
    if (q.scl_s && !q.sda_p && q.sda_s) begin
      d.lk.stop_tgl = ~q.lk.stop_tgl;
    end
    if (!q.rst_s) begin
      // keep sampling the reset; pin synchronisers idle high so no false edge follows
      d = '0;
      d.rst_m = rst_n_i;
      d.rst_s = q.rst_m;
      d.scl_m = 1'b1;
      d.scl_s = 1'b1;
      d.sda_m = 1'b1;
      d.sda_s = 1'b1;
      d.sda_p = 1'b1;
      d.lk.scl_lvl = 1'b1;
      d.lk.sda_lvl = 1'b1;
    end
  end

  always_ff @(posedge link_clk_i) begin
    q <= d;
  end

  // pins only ever pulled low; enables come straight from flops
  assign link_o = q.lk;
  assign serial_clock_pin_o = q.lvl;
  assign serial_clock_pin_oe_o = q.sclr_s;
  assign serial_data_pin_o = q.lvl;
  assign serial_data_pin_oe_o = q.sdar_s;

endmodule : smblt_link_fe
`default_nettype wire

// ### smblt_link_timeouts.sv
// smblt_link_timeouts: two-wire bus timing for a battery pack manager
// slave stretching, master broadcasts, clock-low timeout and idle reset
// assumes ctrl_i is synchronous to sys_clk_i; pins arrive via the front end
`timescale 1ns/1ps
`default_nettype none
module smblt_link_timeouts #(
  parameter int unsigned TIMEOUT_CYC = smblt_pkg::TIMEOUT_CYC,
  parameter int unsigned HIGH_CYC = smblt_pkg::HIGH_CYC,
  parameter int unsigned SEXT_CYC = smblt_pkg::SEXT_CYC,
  parameter int unsigned MEXT_CYC = smblt_pkg::MEXT_CYC,
  parameter logic [7:0] CHARGER_ADDR_W = 8'h12,
  parameter logic [7:0] CMD_CURRENT = 8'h14,
  parameter logic [7:0] CMD_VOLTAGE = 8'h15
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic link_clk_i,
  input wire smblt_pkg::smblt_ctrl_t ctrl_i,
  input wire logic serial_clock_pin_i,
  input wire logic serial_data_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_o,
  output logic serial_data_pin_o,
  output logic serial_data_pin_oe_o,
  output var smblt_pkg::smblt_status_t status_o
);
  import smblt_pkg::*;

  // refuse counts the counters cannot hold
  if (TIMEOUT_CYC >= (1 << CNT_W) || SEXT_CYC >= (1 << CNT_W) ||
      MEXT_CYC >= (1 << CNT_W) || HIGH_CYC >= (1 << CNT_W) ||
      HALF_CYC >= (1 << TMR_W) || HALF_CYC < 1) begin : g_bad_cfg
    $error("smblt_link_timeouts: count exceeds counter width");
  end

  typedef struct packed {
    smblt_state_t st;
    logic scl_m, scl_s, sda_m, sda_s;
    logic stt_m, stt_s, stt_p;
    logic stp_m, stp_s, stp_p;
    logic [CNT_W-1:0] low_cnt;
    logic [CNT_W-1:0] high_cnt;
    logic [CNT_W-1:0] sext_cnt;
    logic [CNT_W-1:0] mext_cnt;
    logic [TMR_W-1:0] tmr;
    logic [3:0] bit_idx;
    logic [1:0] byte_idx;
    logic msg_idx;
    logic pend;
    logic [15:0] cur_q;
    logic [15:0] volt_q;
    logic scl_low;
    logic sda_low;
    smblt_status_t sts;
  } smblt_sys_t;

  smblt_sys_t q, d;
  smblt_link_t link;
  logic [CNT_W-1:0] high_lim;
  logic start_ev, stop_ev, scl, sda, tx_bit;
  logic [7:0] tx_byte;

  localparam logic [CNT_W-1:0] TO_LIM = CNT_W'(TIMEOUT_CYC);
  localparam logic [CNT_W-1:0] HI_STD = CNT_W'(HIGH_CYC);
  localparam logic [CNT_W-1:0] SEXT_LIM = CNT_W'(SEXT_CYC);
  localparam logic [CNT_W-1:0] MEXT_LIM = CNT_W'(MEXT_CYC);
  localparam logic [TMR_W-1:0] HALF = TMR_W'(HALF_CYC);
  localparam logic [CNT_W-1:0] US_MUL = CNT_W'(US_CYC);
  localparam logic [CNT_W-1:0] CNT_MAX = '1;

  // byte of the broadcast frame: address, command, low data, high data
  function automatic logic [7:0] frame_byte(input logic msg, input logic [1:0] idx,
                                            input logic [15:0] cur, input logic [15:0] volt);
    logic [15:0] word;
    word = msg ? volt : cur;
    case (idx)
      2'h0: frame_byte = CHARGER_ADDR_W;
      2'h1: frame_byte = msg ? CMD_VOLTAGE : CMD_CURRENT;
      2'h2: frame_byte = word[7:0];
      default: frame_byte = word[15:8];
    endcase
  endfunction : frame_byte

  smblt_link_fe u_link_fe (
    .link_clk_i(link_clk_i),
    .rst_n_i(rst_n_i),
    .serial_clock_pin_i(serial_clock_pin_i),
    .serial_data_pin_i(serial_data_pin_i),
    .scl_low_req_i(q.scl_low),
    .sda_low_req_i(q.sda_low),
    .link_o(link),
    .serial_clock_pin_o(serial_clock_pin_o),
    .serial_clock_pin_oe_o(serial_clock_pin_oe_o),
    .serial_data_pin_o(serial_data_pin_o),
    .serial_data_pin_oe_o(serial_data_pin_oe_o)
  );

  // decoded views of the synchronised link
  assign scl = q.scl_s;
  assign sda = q.sda_s;
  assign start_ev = q.stt_s ^ q.stt_p;
  assign stop_ev = q.stp_s ^ q.stp_p;
  assign high_lim = ctrl_i.clock_high_limit_select ?
                    CNT_W'(ctrl_i.clock_high_limit_value) * US_MUL : HI_STD;
  assign tx_byte = frame_byte(q.msg_idx, q.byte_idx, q.cur_q, q.volt_q);
  assign tx_bit = (q.bit_idx == ACK_BIT) ? 1'b1 : tx_byte[MSB_POS - q.bit_idx[2:0]];

  // whole next state of the system side
  always_comb begin
    d = q;
    d.sts.timeout_err = 1'b0;
    d.sts.idle_reset = 1'b0;
    d.sts.slave_stretch_over = 1'b0;
    d.sts.master_stretch_over = 1'b0;
    d.sts.master_nack = 1'b0;
    d.sts.broadcast_done = 1'b0;

    // levels and toggles cross through two flops each
    d.scl_m = link.scl_lvl;
    d.scl_s = q.scl_m;
    d.sda_m = link.sda_lvl;
    d.sda_s = q.sda_m;
    d.stt_m = link.start_tgl;
    d.stt_s = q.stt_m;
    d.stt_p = q.stt_s;
    d.stp_m = link.stop_tgl;
    d.stp_s = q.stp_m;
    d.stp_p = q.stp_s;

    // clock level interval counters, saturating
    d.low_cnt = scl ? '0 : ((q.low_cnt == CNT_MAX) ? q.low_cnt : q.low_cnt + 1'b1);
    // a start opens a fresh high interval; idle time before it must not count
    d.high_cnt = (!scl || start_ev) ? '0 :
                 ((q.high_cnt == CNT_MAX) ? q.high_cnt : q.high_cnt + 1'b1);
    d.sts.bus_free = (q.high_cnt >= high_lim) && sda && !start_ev;

    // stretch budgets restart with each message
    if (start_ev || stop_ev) begin
      d.sext_cnt = '0;
      d.mext_cnt = '0;
    end

    // a new broadcast request is latched while nothing is pending and the master is not busy
    if (ctrl_i.broadcast_req && !q.pend && !q.sts.master_busy) begin
      d.pend = 1'b1;
      d.msg_idx = 1'b0;
      d.cur_q = ctrl_i.charge_current;
      d.volt_q = ctrl_i.charge_voltage;
    end

    case (q.st)
      ST_IDLE: begin
        d.scl_low = 1'b0;
        d.sda_low = 1'b0;
        if (start_ev) begin
          d.st = ST_SLAVE;
        end else if (q.pend && q.sts.bus_free) begin
          d.st = ST_M_START;
          d.sda_low = 1'b1;
          d.tmr = HALF;
          d.sts.master_busy = 1'b1;
        end
      end
      ST_SLAVE: begin
        d.sts.slave_active = 1'b1;
        // stretch only inside a low phase and within the budget
        if (ctrl_i.slave_stretch_req && (q.scl_low || !scl) && q.sext_cnt < SEXT_LIM) begin
          d.scl_low = 1'b1;
          d.sext_cnt = q.sext_cnt + 1'b1;
          if (q.sext_cnt == SEXT_LIM - 1'b1) begin
            d.scl_low = 1'b0;
            d.sts.slave_stretch_over = 1'b1;
          end
        end else begin
          d.scl_low = 1'b0;
        end
        if (stop_ev) begin
          d.st = ST_IDLE;
          d.scl_low = 1'b0;
          d.sts.slave_active = 1'b0;
        end else if (q.high_cnt > high_lim) begin
          d.st = ST_IDLE;
          d.scl_low = 1'b0;
          d.sts.slave_active = 1'b0;
          d.sts.idle_reset = 1'b1;
        end
      end
      ST_M_START: begin
        if (q.tmr == '0) begin
          d.scl_low = 1'b1;
          d.st = ST_M_LOW;
          d.bit_idx = '0;
          d.byte_idx = '0;
          d.tmr = HALF;
        end else begin
          d.tmr = q.tmr - 1'b1;
        end
      end
      ST_M_LOW: begin
        d.sda_low = !tx_bit;
        if (q.tmr == '0) begin
          d.scl_low = 1'b0;
          d.st = ST_M_HIGH;
          d.tmr = HALF;
        end else begin
          d.tmr = q.tmr - 1'b1;
        end
      end
      ST_M_HIGH: begin
        // a low clock here is a slave stretching; hold the half period
        if (scl && q.tmr != '0) begin
          d.tmr = q.tmr - 1'b1;
        end else if (scl) begin
          d.scl_low = 1'b1;
          d.tmr = HALF;
          d.st = ST_M_LOW;
          d.bit_idx = q.bit_idx + 1'b1;
          if (q.bit_idx == ACK_BIT) begin
            d.bit_idx = '0;
            d.byte_idx = q.byte_idx + 1'b1;
            if (sda) begin
              d.sts.master_nack = 1'b1;
              d.pend = 1'b0;
              d.st = ST_M_STOP_LOW;
            end else if (q.byte_idx == LAST_BYTE) begin
              d.st = ST_M_STOP_LOW;
            end
          end
        end
      end
      ST_M_STOP_LOW: begin
        d.sda_low = 1'b1;
        if (q.tmr == '0) begin
          d.scl_low = 1'b0;
          d.st = ST_M_STOP_HIGH;
          d.tmr = HALF;
        end else begin
          d.tmr = q.tmr - 1'b1;
        end
      end
      ST_M_STOP_HIGH: begin
        if (scl && q.tmr != '0) begin
          d.tmr = q.tmr - 1'b1;
        end else if (scl) begin
          d.sda_low = 1'b0;
          d.st = ST_IDLE;
          // second message follows once bus_free holds; the stop's high clock counts toward it
          if (q.pend && !q.msg_idx) begin
            d.msg_idx = 1'b1;
            d.sts.master_busy = 1'b0;
          end else begin
            d.sts.broadcast_done = q.pend;
            d.pend = 1'b0;
            d.sts.master_busy = 1'b0;
          end
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase

    // master hold time per message, counted while this side pulls the clock
    if (q.sts.master_busy && q.scl_low) begin
      d.mext_cnt = q.mext_cnt + 1'b1;
    end

    // aborts override whatever the state machine chose
    if (q.low_cnt == TO_LIM && q.st != ST_IDLE) begin
      d.st = ST_IDLE;
      d.sts.timeout_err = 1'b1;
    end
    if (q.sts.master_busy && q.mext_cnt >= MEXT_LIM) begin
      d.st = ST_IDLE;
      d.sts.master_stretch_over = 1'b1;
    end
    if (d.sts.timeout_err || d.sts.master_stretch_over) begin
      d.scl_low = 1'b0;
      d.sda_low = 1'b0;
      // only a master abort drops the request; one latched now survives
      d.pend = d.pend && !q.sts.master_busy;
      d.sts.master_busy = 1'b0;
      d.sts.slave_active = 1'b0;
    end

    if (!rst_n_i) begin
      d = '0;
      d.st = ST_IDLE;
      d.scl_m = 1'b1;
      d.scl_s = 1'b1;
      d.sda_m = 1'b1;
      d.sda_s = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    q <= d;
  end

  assign status_o = q.sts;

endmodule : smblt_link_timeouts
`default_nettype wire

// ### smblt_link_timeouts_checker.sv
// smblt_link_timeouts_checker: timing assertions on the block's ports
// assumes its parameters match the bound instance; bound from the bench
`timescale 1ns/1ps
`default_nettype none
module smblt_link_timeouts_checker #(
  parameter int unsigned TIMEOUT_CYC = 3000,
  parameter int unsigned HIGH_CYC = 500,
  parameter int unsigned SEXT_CYC = 2000,
  parameter int unsigned MEXT_CYC = 20000
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic link_clk_i,
  input wire smblt_pkg::smblt_ctrl_t ctrl_i,
  input wire logic serial_clock_pin_i,
  input wire logic serial_data_pin_i,
  input wire logic serial_clock_pin_o,
  input wire logic serial_clock_pin_oe_o,
  input wire logic serial_data_pin_o,
  input wire logic serial_data_pin_oe_o,
  input wire smblt_pkg::smblt_status_t status_o
);
  import smblt_pkg::*;
  logic [23:0] lo_q, hi_q, ml_q, sx_q, lim;
  // selected clock-high limit in system cycles
  assign lim = ctrl_i.clock_high_limit_select ?
    24'(ctrl_i.clock_high_limit_value) * 24'h64 : 24'(HIGH_CYC);
  // wire and clock-drive run lengths, slave pull total; the design lags the wire by its synchronisers
  always_ff @(posedge sys_clk_i) begin
    lo_q <= (!rst_n_i || serial_clock_pin_i) ? 24'h0 : lo_q + 24'h1;
    hi_q <= (!rst_n_i || !serial_clock_pin_i) ? 24'h0 : hi_q + 24'h1;
    ml_q <= serial_clock_pin_oe_o ? ml_q + 24'h1 : 24'h0;
    sx_q <= !status_o.slave_active ? 24'h0 : sx_q + 24'(serial_clock_pin_oe_o);
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence bcast_s; $rose(status_o.master_busy); endsequence
  sequence start_s; ##[0:40] (serial_data_pin_oe_o && !serial_clock_pin_oe_o); endsequence
  sequence released_s; ##[1:40] (!serial_clock_pin_oe_o && !serial_data_pin_oe_o); endsequence
  start_drive_a: assert property (bcast_s |-> start_s)
    else $error("broadcast start not driven");
  free_first_a: assert property (bcast_s |-> $past(status_o.bus_free))
    else $error("broadcast began on a busy bus");
  half_low_a: assert property ($fell(serial_clock_pin_oe_o) && status_o.master_busy
    |-> ml_q >= 950 && ml_q <= 1000) else $error("master clock low off length");
  to_early_a: assert property ($rose(status_o.timeout_err) |-> lo_q >= TIMEOUT_CYC)
    else $error("timeout too early");
  to_late_a: assert property (lo_q == TIMEOUT_CYC + 40
    |-> !status_o.slave_active && !status_o.master_busy) else $error("timeout missed");
  to_release_a: assert property (status_o.timeout_err |-> released_s)
    else $error("lines held after timeout");
  idle_release_a: assert property (status_o.idle_reset |-> released_s)
    else $error("lines held after idle reset");
  idle_limit_a: assert property (status_o.idle_reset |-> hi_q >= lim)
    else $error("idle reset before limit");
  sx_release_a: assert property (status_o.slave_stretch_over
    |-> ##[1:40] !serial_clock_pin_oe_o) else $error("slave stretch not released");
  sx_budget_a: assert property (sx_q <= SEXT_CYC + 40)
    else $error("slave stretch over budget");
  mx_release_a: assert property (status_o.master_stretch_over
    |-> ##[1:40] !serial_clock_pin_oe_o) else $error("master stretch not released");
endmodule : smblt_link_timeouts_checker
`default_nettype wire

// ### smblt_host_model.sv
// smblt_host_model: far-side party, a host master or a charger slave
// assumes the bench resolves the open-drain wires with pull-ups
`timescale 1ns/1ps
`default_nettype none
module smblt_host_model (
  input wire logic sys_clk_i,
  input wire logic scl_w_i,
  input wire logic sda_w_i,
  output logic scl_low_o,
  output logic sda_low_o,
  output logic [8:0] bits_o
);
  // released lines stand high; clock stands still outside frames
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
    bits_o = 9'h000;
  end
  // data on each clock rise; charger pulls the ninth bit only when the bench drives it, else a nack
  always @(posedge scl_w_i) bits_o <= {bits_o[7:0], sda_w_i};
  // pull or release at a clock edge, hold n cycles; n of 0 returns right after the edge
  task automatic drive(input logic c, input logic d, input int n);
    @(posedge sys_clk_i);
    scl_low_o <= c;
    sda_low_o <= d;
    repeat (n) @(posedge sys_clk_i);
  endtask : drive
endmodule : smblt_host_model
`default_nettype wire

// ### smblt_link_timeouts_tb.sv
// smblt_link_timeouts_tb: self-checking bench for the bus timing block
// assumes the checker and host model are compiled before this file
`timescale 1ns/1ps
`default_nettype none
module smblt_link_timeouts_tb;
  import smblt_pkg::*;
  localparam int TO_C = 3000;
  localparam smblt_status_t M_TO = 9'h020;
  localparam smblt_status_t M_IDLE = 9'h010;
  localparam smblt_status_t M_SX = 9'h008;
  localparam smblt_status_t M_MX = 9'h004;
  localparam int MX_C = 20000;
  localparam smblt_status_t M_NACK = 9'h002;
  typedef struct {logic sel; logic [15:0] val; int lim;} smblt_row_t;
  // limit selector and value beside the idle time they give
  smblt_row_t rows [3] = '{'{1'b0, 16'h0000, 500}, '{1'b1, 16'h0003, 300},
    '{1'b1, 16'h0008, 800}};
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl_oe, sda_oe, scl_o, sda_o, h_scl, h_sda;
  logic [8:0] bits;
  wire logic scl_w, sda_w;
  smblt_ctrl_t ctrl = '0;
  smblt_status_t st;
  int failures = 0;
  int compares = 0;
  int n;
  int held = 0;
  // open-drain wires with pull-ups
  assign scl_w = !(scl_oe || h_scl);
  assign sda_w = !(sda_oe || h_sda);
  smblt_link_timeouts #(.TIMEOUT_CYC(TO_C), .HIGH_CYC(500), .SEXT_CYC(2000),
    .MEXT_CYC(MX_C)) dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .link_clk_i(link_clk),
    .ctrl_i(ctrl), .serial_clock_pin_i(scl_w), .serial_data_pin_i(sda_w),
    .serial_clock_pin_o(scl_o), .serial_clock_pin_oe_o(scl_oe),
    .serial_data_pin_o(sda_o), .serial_data_pin_oe_o(sda_oe), .status_o(st));
  smblt_host_model host (.sys_clk_i(sys_clk), .scl_w_i(scl_w), .sda_w_i(sda_w),
    .scl_low_o(h_scl), .sda_low_o(h_sda), .bits_o(bits));
  // clocks of unrelated phase
  initial forever #5 sys_clk = !sys_clk;
  initial begin
    #17;
    forever #32 link_clk = !link_clk;
  end
  // cycles the master holds the clock low within its own message
  always @(negedge sys_clk) begin
    if (st.master_busy && scl_oe) begin
      held++;
    end
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] lo, input logic [23:0] hi);
    compares++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask : chk
  // sample on the falling edge, where status has settled
  task automatic wait_st(input smblt_status_t m, input int lim, output int k);
    k = 0;
    while ((st & m) === 9'h000 && k < lim) begin
      @(negedge sys_clk);
      k++;
    end
  endtask : wait_st
  task automatic give_verdict();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  initial begin
    // the link side needs three of its own edges inside reset
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    chk(24'({scl_oe, sda_oe, scl_o, sda_o, st}), 24'h0, 24'h0);
    // start, one low, then clock left high until the idle reset
    foreach (rows[i]) begin
      @(posedge sys_clk);
      ctrl.clock_high_limit_select <= rows[i].sel;
      ctrl.clock_high_limit_value <= rows[i].val;
      host.drive(1'b0, 1'b1, 100);
      host.drive(1'b1, 1'b1, 500);
      host.drive(1'b0, 1'b1, 0);
      wait_st(M_IDLE, 2000, n);
      chk(24'(n), 24'(rows[i].lim), 24'(rows[i].lim + 60));
      repeat (40) @(negedge sys_clk);
      chk(24'({st.slave_active, scl_oe, sda_oe}), 24'h0, 24'h0);
      host.drive(1'b0, 1'b0, 900);
    end
    // clock held low by the host past the timeout
    @(posedge sys_clk);
    ctrl.clock_high_limit_select <= 1'b0;
    host.drive(1'b0, 1'b1, 100);
    host.drive(1'b1, 1'b1, 0);
    wait_st(M_TO, 4000, n);
    chk(24'(n), 24'(TO_C), 24'(TO_C + 60));
    repeat (40) @(negedge sys_clk);
    chk(24'({st.slave_active, scl_oe, sda_oe}), 24'h0, 24'h0);
    host.drive(1'b1, 1'b0, 500);
    host.drive(1'b0, 1'b0, 900);
    // slave stretch runs out of budget while the host waits
    @(posedge sys_clk);
    ctrl.slave_stretch_req <= 1'b1;
    host.drive(1'b0, 1'b1, 100);
    host.drive(1'b1, 1'b1, 500);
    host.drive(1'b0, 1'b1, 0);
    wait_st(M_SX, 3000, n);
    chk(24'(n), 24'd1400, 24'd1600);
    repeat (40) @(negedge sys_clk);
    chk(24'(scl_w), 24'h1, 24'h1);
    @(posedge sys_clk);
    ctrl.slave_stretch_req <= 1'b0;
    host.drive(1'b0, 1'b0, 900);
    // broadcast request; the charger refuses its address
    @(posedge sys_clk);
    ctrl.charge_current <= 16'h1234;
    ctrl.charge_voltage <= 16'h4321;
    ctrl.broadcast_req <= 1'b1;
    @(posedge sys_clk);
    ctrl.broadcast_req <= 1'b0;
    wait_st(M_NACK, 30000, n);
    chk(24'(n), 24'd16000, 24'd20000);
    chk(24'(bits), 24'({8'h12, 1'b1}), 24'({8'h12, 1'b1}));
    repeat (3000) @(negedge sys_clk);
    chk(24'({st.master_busy, scl_oe, sda_oe}), 24'h0, 24'h0);
    // charger acks two bytes; the master hold budget then ends the message
    @(posedge sys_clk);
    held = 0;
    ctrl.broadcast_req <= 1'b1;
    @(posedge sys_clk);
    ctrl.broadcast_req <= 1'b0;
    repeat (2) begin
      repeat (8) @(posedge scl_w);
      @(negedge scl_w);
      host.drive(1'b0, 1'b1, 0);
      @(negedge scl_w);
      host.drive(1'b0, 1'b0, 0);
    end
    wait_st(M_MX, 8000, n);
    chk(24'(n), 24'd0, 24'd7999);
    chk(24'(held), 24'(MX_C - 200), 24'(MX_C + 50));
    repeat (40) @(negedge sys_clk);
    chk(24'({st.master_busy, scl_oe, sda_oe}), 24'h0, 24'h0);
    give_verdict();
  end
  // watchdog: the whole sequence needs under 0.8 ms
  initial begin
    #1_000_000;
    failures++;
    give_verdict();
  end
endmodule : smblt_link_timeouts_tb
bind smblt_link_timeouts smblt_link_timeouts_checker #(.TIMEOUT_CYC(TIMEOUT_CYC),
  .HIGH_CYC(HIGH_CYC), .SEXT_CYC(SEXT_CYC), .MEXT_CYC(MEXT_CYC)) chk_i (.sys_clk_i,
  .rst_n_i, .link_clk_i, .ctrl_i, .serial_clock_pin_i, .serial_data_pin_i,
  .serial_clock_pin_o, .serial_clock_pin_oe_o, .serial_data_pin_o,
  .serial_data_pin_oe_o, .status_o);
`default_nettype wire
